// file: cfp_can_fault_prot.sv
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
// Contract
// - Overtemperature of the driver stage switches transmission to the bus off.
// - Overtemperature leaves the programmed mode untouched and the driver returns without a host command once cool.
// - After cooling, transmission stays blocked until a dominant-to-recessive edge on the transmit input.
// - A receive pin held recessive during bus traffic is diagnosed and keeps the transmitter off.
// - After such a clamp the transmitter returns only on a host resume command.
// - Supply undervoltage is taken from the auxiliary regulator monitors, not detected locally.
// - A detected bus failure sets the bus-fault flag and raises an interrupt unless masked.
// - Bus failures are either bus line shorted to ground, battery or logic supply.
// - A bus failure changes no mode, only flag and interrupt.
// - The split output is on in normal and receive-only modes and off in wake-capable and off.
// - Every transceiver failure is visible in the diagnostic information the host reads.
// - The interrupt output goes low to signal an unmasked failure event.
module cfp_can_fault_prot
#(
    parameter int CLAMP_CYCLES = cfp_pkg::RXD_CLAMP_CYC,
    parameter int CLAMP_CNT_W  = cfp_pkg::CLAMP_CNT_W
)
(
    input  wire logic                          ref_clk_i,
    input  wire logic                          sys_rst_i,
    input  wire logic                          clk_en_i,
    // register port
    input  wire logic [cfp_pkg::ADDR_W-1:0]    reg_addr_i,
    input  wire logic [cfp_pkg::DATA_W-1:0]    reg_wdata_i,
    input  wire logic                          reg_wr_i,
    input  wire logic                          reg_rd_i,
    output logic      [cfp_pkg::DATA_W-1:0]    reg_rdata_o,
    // host side
    input  wire logic                          txd_i,
    output logic                               rxd_o,
    output logic                               int_n_o,
    // supply monitors
    input  wire logic                          aux_supply_two_uv_i,
    input  wire logic                          aux_supply_three_uv_i,
    // analog front end
    input  wire cfp_pkg::cfp_ana_in_type       ana_i,
    output cfp_pkg::cfp_ana_out_type           ana_o,
    output cfp_pkg::cfp_mode_type              mode_o
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic reg_hit(input logic [cfp_pkg::ADDR_W-1:0] addr,
                                     input logic [cfp_pkg::ADDR_W-1:0] idx);
        reg_hit = (addr == idx);
    endfunction

    function automatic logic split_on(input logic [1:0] mode);
        split_on = (mode == cfp_pkg::CFP_MODE_NORMAL) || (mode == cfp_pkg::CFP_MODE_RX_ONLY);
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    cfp_pkg::cfp_core_state_type st_r;
    cfp_pkg::cfp_core_state_type st_nxt;

    logic                          therm_block;
    logic                          rxd_clamped;
    logic                          resume_cmd;
    logic                          supply_uv;
    logic                          any_fault;
    logic                          tx_enable;
    logic [cfp_pkg::DATA_W-1:0]    diag_word;
    logic                          wr_ctrl;
    logic                          wr_status;
    logic                          wr_mask;
    logic [cfp_pkg::EV_W-1:0]      ev_level;

    // ----------------------------------------
    // protection units
    // ----------------------------------------
    assign wr_ctrl    = reg_wr_i && reg_hit(reg_addr_i, cfp_pkg::REG_CTRL);
    assign wr_status  = reg_wr_i && reg_hit(reg_addr_i, cfp_pkg::REG_STATUS);
    assign wr_mask    = reg_wr_i && reg_hit(reg_addr_i, cfp_pkg::REG_MASK);
    assign resume_cmd = wr_ctrl && reg_wdata_i[cfp_pkg::CTRL_TX_RESUME];

    cfp_thermal_gate u_thermal
    (
        .ref_clk_i  (ref_clk_i),
        .sys_rst_i  (sys_rst_i),
        .clk_en_i   (clk_en_i),
        .overtemp_i (ana_i.overtemp),
        .txd_i      (txd_i),
        .tx_block_o (therm_block)
    );

    cfp_rxd_clamp_det
    #(
        .CNT_W (CLAMP_CNT_W),
        .LIMIT (CLAMP_CYCLES)
    )
    u_clamp
    (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .clk_en_i  (clk_en_i),
        .rxd_pad_i (ana_i.rxd_pad),
        .bus_dom_i (ana_i.bus_dom),
        .resume_i  (resume_cmd),
        .clamped_o (rxd_clamped)
    );

    // ----------------------------------------
    // supply and fault condition
    // ----------------------------------------
    // no local detector: the monitor of whichever regulator feeds the cell
    assign supply_uv = st_r.sup_sel ? aux_supply_three_uv_i : aux_supply_two_uv_i;
    assign any_fault = |ana_i.short_det;

    // thermal and clamp gate the driver only; mode register is never touched
    assign tx_enable = (st_r.mode == cfp_pkg::CFP_MODE_NORMAL)
                       && !therm_block
                       && !rxd_clamped;

    always_comb
    begin
        ev_level                          = '0;
        ev_level[cfp_pkg::EV_BUS_FAULT]   = any_fault;
        ev_level[cfp_pkg::EV_OVERTEMP]    = ana_i.overtemp;
        ev_level[cfp_pkg::EV_RXD_CLAMP]   = rxd_clamped;
        ev_level[cfp_pkg::EV_UNDERVOLT]   = supply_uv;
    end

    // live view of every failure source for the host
    always_comb
    begin
        diag_word                                                        = '0;
        diag_word[cfp_pkg::DIAG_FAULT_LSB +: cfp_pkg::FAULT_W]           = ana_i.short_det;
        diag_word[cfp_pkg::DIAG_THERM_BLK]                               = therm_block;
        diag_word[cfp_pkg::DIAG_CLAMP]                                   = rxd_clamped;
        diag_word[cfp_pkg::DIAG_UV]                                      = supply_uv;
        diag_word[cfp_pkg::DIAG_TX_EN]                                   = tx_enable;
        diag_word[cfp_pkg::DIAG_OT_LIVE]                                 = ana_i.overtemp;
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        st_nxt = st_r;

        // mode only ever changes by host write, never by a fault
        if (wr_ctrl)
        begin
            st_nxt.mode    = reg_wdata_i[cfp_pkg::CTRL_MODE_LSB +: 2];
            st_nxt.sup_sel = reg_wdata_i[cfp_pkg::CTRL_SUP_SEL];
        end

        if (wr_mask)
        begin
            st_nxt.mask = reg_wdata_i[cfp_pkg::EV_W-1:0];
        end

        // write-one-to-clear, a live event in the same cycle wins
        if (wr_status)
        begin
            st_nxt.status = st_r.status & ~reg_wdata_i[cfp_pkg::EV_W-1:0];
        end
        st_nxt.status = st_nxt.status | ev_level;

        // read data valid only in the cycle after the strobe
        st_nxt.rdata = '0;
        if (reg_rd_i)
        begin
            unique case (1'b1)
                reg_hit(reg_addr_i, cfp_pkg::REG_CTRL):
                begin
                    st_nxt.rdata[cfp_pkg::CTRL_MODE_LSB +: 2] = st_r.mode;
                    st_nxt.rdata[cfp_pkg::CTRL_SUP_SEL]       = st_r.sup_sel;
                end
                reg_hit(reg_addr_i, cfp_pkg::REG_STATUS):
                begin
                    st_nxt.rdata[cfp_pkg::EV_W-1:0] = st_r.status;
                end
                reg_hit(reg_addr_i, cfp_pkg::REG_MASK):
                begin
                    st_nxt.rdata[cfp_pkg::EV_W-1:0] = st_r.mask;
                end
                reg_hit(reg_addr_i, cfp_pkg::REG_DIAG):
                begin
                    st_nxt.rdata = diag_word;
                end
                default:
                begin
                    st_nxt.rdata = cfp_pkg::RDATA_RST;
                end
            endcase
        end

        st_nxt.rxd      = ana_i.rxd_cmp;
        // recessive whenever the driver is not allowed to send
        st_nxt.drv_txd  = tx_enable ? txd_i : 1'b1;
        st_nxt.drv_en   = tx_enable;
        st_nxt.split_en = split_on(st_nxt.mode);
        st_nxt.int_n    = ~|(st_nxt.status & ~st_nxt.mask);
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            st_r.mode     <= cfp_pkg::CFP_MODE_OFF;
            st_r.sup_sel  <= cfp_pkg::SUP_RST;
            st_r.status   <= '0;
            st_r.mask     <= cfp_pkg::MASK_RST;
            st_r.rdata    <= cfp_pkg::RDATA_RST;
            st_r.rxd      <= 1'b1;
            st_r.drv_txd  <= 1'b1;
            st_r.drv_en   <= 1'b0;
            st_r.split_en <= 1'b0;
            st_r.int_n    <= 1'b1;
        end
        else if (clk_en_i)
        begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign reg_rdata_o    = st_r.rdata;
    assign rxd_o          = st_r.rxd;
    assign int_n_o        = st_r.int_n;
    assign ana_o.drv_txd  = st_r.drv_txd;
    assign ana_o.drv_en   = st_r.drv_en;
    assign ana_o.split_en = st_r.split_en;
    assign mode_o         = cfp_pkg::cfp_mode_type'(st_r.mode);

endmodule

// file: cfp_pkg.sv
package cfp_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam int         ADDR_W         = 4;
    localparam int         DATA_W         = 16;
    localparam logic [3:0] REG_CTRL       = 4'h0;
    localparam logic [3:0] REG_STATUS     = 4'h1;
    localparam logic [3:0] REG_MASK       = 4'h2;
    localparam logic [3:0] REG_DIAG       = 4'h3;

    // ctrl fields
    localparam int         CTRL_MODE_LSB  = 0;
    localparam int         CTRL_SUP_SEL   = 2;
    localparam int         CTRL_TX_RESUME = 3;

    // status / mask bit positions
    localparam int         EV_BUS_FAULT   = 0;
    localparam int         EV_OVERTEMP    = 1;
    localparam int         EV_RXD_CLAMP   = 2;
    localparam int         EV_UNDERVOLT   = 3;
    localparam int         EV_W           = 4;

    // diag fields
    localparam int         DIAG_FAULT_LSB = 0;
    localparam int         DIAG_THERM_BLK = 6;
    localparam int         DIAG_CLAMP     = 7;
    localparam int         DIAG_UV        = 8;
    localparam int         DIAG_TX_EN     = 9;
    localparam int         DIAG_OT_LIVE   = 10;

    localparam int         FAULT_W        = 6;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [EV_W-1:0]   MASK_RST   = 4'h0;
    localparam logic [DATA_W-1:0] RDATA_RST  = 16'h0000;
    localparam logic              SUP_RST    = 1'b0;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS     = 40;
    // longer than one stuffed frame at the slowest supported bit rate
    localparam int RXD_CLAMP_TIME_US = 1000;
    localparam int RXD_CLAMP_CYC     = (RXD_CLAMP_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int CLAMP_CNT_W       = 16;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {
        CFP_MODE_OFF,
        CFP_MODE_WAKE,
        CFP_MODE_NORMAL,
        CFP_MODE_RX_ONLY
    } cfp_mode_type;

    // analog front end to logic
    typedef struct packed {
        logic               rxd_cmp;    // receiver comparator, 0 = dominant
        logic               rxd_pad;    // sensed level of the host rxd pin
        logic               bus_dom;    // bus seen dominant
        logic               overtemp;   // driver stage above shutdown temp
        logic [FAULT_W-1:0] short_det;  // h:gnd,bat,vcc  l:gnd,bat,vcc
    } cfp_ana_in_type;

    // logic to analog front end
    typedef struct packed {
        logic drv_txd;   // 0 = drive dominant
        logic drv_en;
        logic split_en;
    } cfp_ana_out_type;

    typedef struct packed {
        logic [1:0]        mode;
        logic              sup_sel;
        logic [EV_W-1:0]   status;
        logic [EV_W-1:0]   mask;
        logic [DATA_W-1:0] rdata;
        logic              rxd;
        logic              drv_txd;
        logic              drv_en;
        logic              split_en;
        logic              int_n;
    } cfp_core_state_type;

endpackage

// file: cfp_thermal_gate.sv
`timescale 1ns/1ns
module cfp_thermal_gate
(
    input  wire logic ref_clk_i,
    input  wire logic sys_rst_i,
    input  wire logic clk_en_i,
    input  wire logic overtemp_i,
    input  wire logic txd_i,
    output logic      tx_block_o
);

    typedef struct packed {
        logic blocked;
        logic txd_q;
    } cfp_therm_state_type;

    cfp_therm_state_type st_r;
    cfp_therm_state_type st_nxt;

    always_comb
    begin
        st_nxt       = st_r;
        st_nxt.txd_q = txd_i;
        if (overtemp_i)
        begin
            st_nxt.blocked = 1'b1;
        end
        else if (st_r.blocked && !st_r.txd_q && txd_i)
        begin
            // release only on dominant->recessive so no bit is cut short
            st_nxt.blocked = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            st_r <= '{blocked: 1'b0, txd_q: 1'b1};
        end
        else if (clk_en_i)
        begin
            st_r <= st_nxt;
        end
    end

    assign tx_block_o = st_r.blocked;

endmodule

// file: cfp_rxd_clamp_det.sv
`timescale 1ns/1ns
module cfp_rxd_clamp_det
#(
    parameter int CNT_W  = cfp_pkg::CLAMP_CNT_W,
    parameter int LIMIT  = cfp_pkg::RXD_CLAMP_CYC
)
(
    input  wire logic ref_clk_i,
    input  wire logic sys_rst_i,
    input  wire logic clk_en_i,
    input  wire logic rxd_pad_i,
    input  wire logic bus_dom_i,
    input  wire logic resume_i,
    output logic      clamped_o
);

    localparam logic [CNT_W-1:0] LIMIT_C = CNT_W'(LIMIT);
    localparam logic [CNT_W-1:0] ONE_C   = CNT_W'(1);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             latched;
    } cfp_clamp_state_type;

    cfp_clamp_state_type st_r;
    cfp_clamp_state_type st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (!rxd_pad_i)
        begin
            st_nxt.cnt = '0;
        end
        else if (bus_dom_i && (st_r.cnt < LIMIT_C))
        begin
            st_nxt.cnt = st_r.cnt + ONE_C;
        end
        if (st_nxt.cnt >= LIMIT_C)
        begin
            st_nxt.latched = 1'b1;
        end
        else if (resume_i)
        begin
            // a resume while the pad is still stuck is ignored
            st_nxt.latched = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            st_r <= '{cnt: '0, latched: 1'b0};
        end
        else if (clk_en_i)
        begin
            st_r <= st_nxt;
        end
    end

    assign clamped_o = st_r.latched;

endmodule

// file: cfp_bus_model.sv
`timescale 1ns/1ns
module cfp_bus_model
(
    input  wire logic                        rxd_i,
    input  wire cfp_pkg::cfp_ana_out_type    drv_i,
    input  wire logic                        overtemp_i,
    input  wire logic [cfp_pkg::FAULT_W-1:0] short_i,
    input  wire logic                        pad_stuck_i,
    input  wire logic                        peer_dom_i,
    output cfp_pkg::cfp_ana_in_type          ana_o
);
    logic bus_dom;

    // wired-and bus: any dominant driver wins, the peer included
    assign bus_dom = (drv_i.drv_en && !drv_i.drv_txd) || peer_dom_i;
    // a pin shorted high reads recessive whatever the bus does
    assign ana_o = '{rxd_cmp: !bus_dom, rxd_pad: pad_stuck_i || rxd_i, bus_dom: bus_dom,
                     overtemp: overtemp_i, short_det: short_i};
endmodule

// file: cfp_can_fault_prot_props.sv
`timescale 1ns/1ns
module cfp_fault_props
#(
    parameter int CLAMP_CYCLES = cfp_pkg::RXD_CLAMP_CYC,
    parameter int CLAMP_CNT_W  = cfp_pkg::CLAMP_CNT_W
)
(
    input  wire logic                       ref_clk_i,
    input  wire logic                       sys_rst_i,
    input  wire logic                       clk_en_i,
    input  wire logic [cfp_pkg::ADDR_W-1:0] reg_addr_i,
    input  wire logic [cfp_pkg::DATA_W-1:0] reg_wdata_i,
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    input  wire logic [cfp_pkg::DATA_W-1:0] reg_rdata_o,
    input  wire logic                       txd_i,
    input  wire logic                       int_n_o,
    input  wire cfp_pkg::cfp_ana_in_type    ana_i,
    input  wire cfp_pkg::cfp_ana_out_type   ana_o,
    input  wire cfp_pkg::cfp_mode_type      mode_o
);
    logic [CLAMP_CNT_W-1:0] run_r;
    logic                   mask_r;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    // ----------------------------------------
    // shadow of clamp run and bus-fault mask
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            run_r  <= '0;
            mask_r <= 1'b0;
        end
        else if (clk_en_i)
        begin
            if (!ana_i.rxd_pad)
            begin
                run_r <= '0;
            end
            else if (ana_i.bus_dom && run_r < CLAMP_CNT_W'(CLAMP_CYCLES))
            begin
                run_r <= run_r + CLAMP_CNT_W'(1);
            end
            if (reg_wr_i && reg_addr_i == cfp_pkg::REG_MASK)
            begin
                mask_r <= reg_wdata_i[cfp_pkg::EV_BUS_FAULT];
            end
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    sequence s_hot_idle;
        clk_en_i && ana_i.overtemp && txd_i ##1 (clk_en_i && !ana_i.overtemp && txd_i)[*3];
    endsequence

    a_overtemp_drv_off: assert property (clk_en_i && ana_i.overtemp ##1 clk_en_i |=> !ana_o.drv_en)
        else $error("driver still on while hot");
    a_cool_stays_blocked: assert property (s_hot_idle |=> !ana_o.drv_en)
        else $error("released without txd edge");
    a_mode_write_only: assert property (
        !(clk_en_i && reg_wr_i && reg_addr_i == cfp_pkg::REG_CTRL) |=> $stable(mode_o))
        else $error("mode changed without write");
    a_split_follows_mode: assert property (
        ana_o.split_en == (mode_o == cfp_pkg::CFP_MODE_NORMAL || mode_o == cfp_pkg::CFP_MODE_RX_ONLY))
        else $error("split output wrong for mode");
    a_idle_recessive: assert property (!ana_o.drv_en |-> ana_o.drv_txd)
        else $error("dominant data with driver off");
    a_clamp_blocks_tx: assert property (
        clk_en_i && run_r == CLAMP_CNT_W'(CLAMP_CYCLES) |=> !ana_o.drv_en)
        else $error("driver on during clamp");
    a_fault_raises_int: assert property (
        clk_en_i && (|ana_i.short_det) && !mask_r && !(reg_wr_i && reg_addr_i == cfp_pkg::REG_MASK)
        |=> !int_n_o)
        else $error("bus fault without interrupt");
    a_rdata_one_cycle: assert property ($past(clk_en_i) && !$past(reg_rd_i) |-> reg_rdata_o == '0)
        else $error("read data outside read slot");
endmodule

bind cfp_can_fault_prot cfp_fault_props #(.CLAMP_CYCLES(CLAMP_CYCLES), .CLAMP_CNT_W(CLAMP_CNT_W)) props_u
(
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .txd_i(txd_i), .int_n_o(int_n_o), .ana_i(ana_i), .ana_o(ana_o), .mode_o(mode_o)
);

// file: testbench.sv
`timescale 1ns/1ns
module testbench;
    logic                      ref_clk, sys_rst, reg_wr, reg_rd, txd, two_uv, three_uv;
    logic                      overtemp, pad_stuck, peer_dom, rxd, int_n, clk_en;
    logic [3:0]                reg_addr;
    logic [15:0]               reg_wdata, reg_rdata;
    logic [5:0]                short_det;
    cfp_pkg::cfp_ana_in_type   ana_i;
    cfp_pkg::cfp_ana_out_type  ana_o;
    cfp_pkg::cfp_mode_type     mode_o;
    int                        bad_count, samples_checked, cyc;

    cfp_can_fault_prot #(.CLAMP_CYCLES(8)) dut_u
    (
        .ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .clk_en_i(clk_en), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
        .txd_i(txd), .rxd_o(rxd), .int_n_o(int_n), .aux_supply_two_uv_i(two_uv),
        .aux_supply_three_uv_i(three_uv), .ana_i(ana_i), .ana_o(ana_o), .mode_o(mode_o)
    );
    cfp_bus_model bus_u
    (
        .rxd_i(rxd), .drv_i(ana_o), .overtemp_i(overtemp), .short_i(short_det),
        .pad_stuck_i(pad_stuck), .peer_dom_i(peer_dom), .ana_o(ana_i)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp, input string what);
        cmp_word({15'h0000, got}, {15'h0000, exp}, what);
    endtask
    // strobes drop for a cycle so back-to-back calls never reassign in one step
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        step(1);
        reg_wr <= 1'b0;
        step(1);
    endtask
    task automatic chk_reg(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e, input string what);
        reg_rd <= 1'b1;
        reg_addr <= a;
        step(1);
        reg_rd <= 1'b0;
        cmp_word(reg_rdata & m, e, what);
        step(1);
    endtask
    task automatic summarize;
        if (bad_count == 0 && samples_checked > 0)
        begin
            $display("Test passed");
        end
        else
        begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs_split;
        chk_reg(cfp_pkg::REG_STATUS, 16'hFFFF, 16'h0000, "status reset");
        chk_reg(cfp_pkg::REG_MASK, 16'hFFFF, 16'h0000, "mask reset");
        chk_reg(4'hF, 16'hFFFF, 16'h0000, "unmapped");
        cmp_bit(int_n, 1'b1, "idle int");
        for (int m = 0; m < 4; m++)
        begin
            wr(cfp_pkg::REG_CTRL, 16'(m) | 16'h0008);
            cmp_bit(ana_o.split_en, m >= 2, "split");
            cmp_word(16'(mode_o), 16'(m), "mode");
        end
        chk_reg(cfp_pkg::REG_CTRL, 16'h000F, 16'h0003, "ctrl readback");
    endtask
    task automatic t_thermal;
        wr(cfp_pkg::REG_CTRL, 16'h0002);
        overtemp <= 1'b1;
        step(3);
        cmp_bit(ana_o.drv_en, 1'b0, "hot driver");
        cmp_word(16'(mode_o), 16'h0002, "hot mode");
        overtemp <= 1'b0;
        step(4);
        cmp_bit(ana_o.drv_en, 1'b0, "cooled, no edge");
        txd <= 1'b0;
        step(1);
        txd <= 1'b1;
        step(2);
        cmp_bit(ana_o.drv_en, 1'b1, "released");
        txd <= 1'b0;
        step(2);
        cmp_bit(ana_o.drv_txd, 1'b0, "dominant out");
        cmp_bit(rxd, 1'b0, "echo");
        txd <= 1'b1;
        wr(cfp_pkg::REG_STATUS, 16'h0002);
        cmp_bit(int_n, 1'b1, "hot clear");
    endtask
    task automatic t_faults;
        for (int i = 0; i < 6; i++)
        begin
            short_det <= 6'h01 << i;
            step(2);
            cmp_bit(int_n, 1'b0, "fault int");
            chk_reg(cfp_pkg::REG_DIAG, 16'h003F, 16'h0001 << i, "fault diag");
            cmp_word(16'(mode_o), 16'h0002, "fault mode");
            cmp_bit(ana_o.drv_en, 1'b1, "fault driver");
            short_det <= 6'h00;
            wr(cfp_pkg::REG_STATUS, 16'h0001);
            cmp_bit(int_n, 1'b1, "fault clear");
        end
        wr(cfp_pkg::REG_MASK, 16'h0001);
        short_det <= 6'h20;
        step(2);
        cmp_bit(int_n, 1'b1, "masked int");
        chk_reg(cfp_pkg::REG_STATUS, 16'h000F, 16'h0001, "masked flag");
        short_det <= 6'h00;
        wr(cfp_pkg::REG_STATUS, 16'h0001);
        wr(cfp_pkg::REG_MASK, 16'h0000);
    endtask
    task automatic t_clamp;
        pad_stuck <= 1'b1;
        peer_dom <= 1'b1;
        step(12);
        cmp_bit(ana_o.drv_en, 1'b0, "clamped");
        txd <= 1'b0;
        step(2);
        cmp_bit(ana_o.drv_txd, 1'b1, "clamped data");
        txd <= 1'b1;
        chk_reg(cfp_pkg::REG_DIAG, 16'h0080, 16'h0080, "clamp diag");
        wr(cfp_pkg::REG_CTRL, 16'h000A);
        step(2);
        cmp_bit(ana_o.drv_en, 1'b0, "resume while stuck");
        pad_stuck <= 1'b0;
        step(3);
        peer_dom <= 1'b0;
        step(3);
        cmp_bit(ana_o.drv_en, 1'b0, "no command");
        wr(cfp_pkg::REG_CTRL, 16'h000A);
        cmp_bit(ana_o.drv_en, 1'b1, "resumed");
        chk_reg(cfp_pkg::REG_STATUS, 16'h0004, 16'h0004, "clamp flag");
        wr(cfp_pkg::REG_STATUS, 16'h0004);
    endtask
    task automatic t_supply;
        two_uv <= 1'b1;
        step(2);
        chk_reg(cfp_pkg::REG_DIAG, 16'h0100, 16'h0100, "uv two");
        two_uv <= 1'b0;
        three_uv <= 1'b1;
        step(2);
        chk_reg(cfp_pkg::REG_DIAG, 16'h0100, 16'h0000, "uv unselected");
        wr(cfp_pkg::REG_CTRL, 16'h0006);
        chk_reg(cfp_pkg::REG_DIAG, 16'h0100, 16'h0100, "uv three");
        cmp_bit(int_n, 1'b0, "uv int");
        wr(cfp_pkg::REG_CTRL, 16'h0004);
        cmp_bit(ana_o.split_en, 1'b0, "off split");
        cmp_bit(ana_o.drv_en, 1'b0, "off driver");
        three_uv <= 1'b0;
        wr(cfp_pkg::REG_STATUS, 16'h0008);
        cmp_bit(int_n, 1'b1, "uv clear");
        // a write while the clock enable is low must be lost
        clk_en <= 1'b0;
        wr(cfp_pkg::REG_CTRL, 16'h0002);
        cmp_word(16'(mode_o), 16'h0000, "frozen mode");
        clk_en <= 1'b1;
        step(1);
    endtask

    // ----------------------------------------
    // clock, watchdog, main sequence
    // ----------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            bad_count++;
            summarize();
        end
    end
    initial
    begin
        {reg_wr, reg_rd, two_uv, three_uv, overtemp, pad_stuck, peer_dom} = '0;
        {reg_addr, reg_wdata, short_det} = '0;
        txd = 1'b1;
        clk_en = 1'b1;
        sys_rst = 1'b1;
        step(4);
        sys_rst <= 1'b0;
        step(1);
        t_regs_split();
        t_thermal();
        t_faults();
        t_clamp();
        t_supply();
        summarize();
    end
endmodule
